/* File: rtl/sepc_params.svh */
// Named constants for the serial EEPROM pin-control front end.
// Assumes a 32-bit Avalon-MM slave port with byte addresses on four bits.
`ifndef SEPC_PARAMS_SVH
`define SEPC_PARAMS_SVH

`define SEPC_ADDR_W 4
`define SEPC_DATA_W 32
`define SEPC_OFF_CTRL 4'h0
`define SEPC_OFF_STAT 4'h4
`define SEPC_OFF_RX 4'h8
`define SEPC_OFF_TX 4'hC

`define SEPC_CTL_SETWEL 0
`define SEPC_CTL_CLRWEL 1
`define SEPC_CTL_START 2
`define SEPC_CTL_DONE 3
`define SEPC_CTL_RXACK 4
`define SEPC_CTL_CLRREF 5

`define SEPC_ST_BUSY 0
`define SEPC_ST_WEL 1
`define SEPC_ST_NV_LSB 2
`define SEPC_ST_NV_MSB 4
`define SEPC_ST_SEL 5
`define SEPC_ST_PAUSE 6
`define SEPC_ST_RXFULL 7
`define SEPC_ST_WPLOW 8
`define SEPC_ST_REFUSED 9
`define SEPC_ST_ACTIVE 10

`define SEPC_BIT_LAST 3'h7
`define SEPC_BIT_FIRST 3'h0
`define SEPC_BIT_ONE 3'h1
`define SEPC_TX_RST 8'hFF
`define SEPC_BYTE_RST 8'h00
`define SEPC_NV_RST 3'h0
`define SEPC_SYNC_RST 5'h03
`define SEPC_WORD_ZERO 32'h0000_0000

`endif

/* File: rtl/sepc_pkg.sv */
// Types shared by the serial EEPROM pin-control front end.
// Assumes nothing beyond a SystemVerilog compiler.
package sepc_pkg;

  typedef struct packed {
    logic sclk;
    logic selN;
    logic mosi;
    logic holdN;
    logic wpN;
  } sepc_pins_t;

  typedef enum logic [1:0] {IF_UNARMED, IF_DESEL, IF_ACTIVE, IF_PAUSED} sepc_if_t;

  typedef enum logic [2:0] {REG_CTRL, REG_STAT, REG_RX, REG_TX, REG_NONE} sepc_reg_t;

endpackage

/* File: rtl/sepc_pin_ctrl.sv */
// Pin-level front end of a small serial EEPROM slave: select, pause, protect, shifting.
// Assumes the pins arrive asynchronously and software reaches it over Avalon-MM.
`timescale 1ns/1ps
`include "sepc_params.svh"

module sepc_pin_ctrl (
  input logic clk,
  input logic arst_n,
  input sepc_pkg::sepc_pins_t pinsIn,
  input logic [2:0] nvBits,
  input logic [`SEPC_ADDR_W-1:0] avs_address,
  input logic avs_read,
  input logic avs_write,
  input logic [`SEPC_DATA_W-1:0] avs_writedata,
  output logic [`SEPC_DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  output logic miso,
  output logic misoOe,
  output logic activeMode
);

  function automatic sepc_pkg::sepc_reg_t regSel(input logic [`SEPC_ADDR_W-1:0] addr);
    case (addr)
      `SEPC_OFF_CTRL: regSel = sepc_pkg::REG_CTRL;
      `SEPC_OFF_STAT: regSel = sepc_pkg::REG_STAT;
      `SEPC_OFF_RX: regSel = sepc_pkg::REG_RX;
      `SEPC_OFF_TX: regSel = sepc_pkg::REG_TX;
      default: regSel = sepc_pkg::REG_NONE;
    endcase
  endfunction

  // Pin synchronisers; the first stage feeds only the second.
  sepc_pkg::sepc_pins_t syncA_r, syncA_nxt, syncB_r, syncB_nxt;
  logic sclkPrev_r, sclkPrev_nxt;

  always_comb
  begin
    syncA_nxt = pinsIn;
    syncB_nxt = syncA_r;
    sclkPrev_nxt = syncB_r.sclk;
  end

  // Selection resets to zero so the unarmed state must see a real high.
  // Pause and protect reset to their idle high levels, so no false protect shows after reset.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      syncA_r <= `SEPC_SYNC_RST;
      syncB_r <= `SEPC_SYNC_RST;
      sclkPrev_r <= 1'b0;
    end
    else
    begin
      syncA_r <= syncA_nxt;
      syncB_r <= syncB_nxt;
      sclkPrev_r <= sclkPrev_nxt;
    end
  end

  logic sclkRise;
  logic sclkFall;
  assign sclkRise = syncB_r.sclk & ~sclkPrev_r;
  assign sclkFall = ~syncB_r.sclk & sclkPrev_r;

  // Interface state.
  sepc_pkg::sepc_if_t state_r, state_nxt;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      sepc_pkg::IF_UNARMED:
      begin
        if (syncB_r.selN)
          state_nxt = sepc_pkg::IF_DESEL;
      end
      sepc_pkg::IF_DESEL:
      begin
        if (!syncB_r.selN)
          state_nxt = sepc_pkg::IF_ACTIVE;
      end
      sepc_pkg::IF_ACTIVE:
      begin
        if (syncB_r.selN)
          state_nxt = sepc_pkg::IF_DESEL;
        else if (!syncB_r.holdN && !syncB_r.sclk)
          state_nxt = sepc_pkg::IF_PAUSED;
      end
      sepc_pkg::IF_PAUSED:
      begin
        if (syncB_r.selN)
          state_nxt = sepc_pkg::IF_DESEL;
        else if (syncB_r.holdN && !syncB_r.sclk)
          state_nxt = sepc_pkg::IF_ACTIVE;
      end
      default:
        state_nxt = sepc_pkg::IF_UNARMED;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      state_r <= sepc_pkg::IF_UNARMED;
    else
      state_r <= state_nxt;
  end

  // Shift path.
  logic [2:0] bitCnt_r, bitCnt_nxt;
  logic [7:0] rxShift_r, rxShift_nxt;
  logic [7:0] rxData_r, rxData_nxt;
  logic [7:0] txShift_r, txShift_nxt;
  logic [7:0] txData_r, txData_nxt;
  logic rxFull_r, rxFull_nxt;
  logic miso_r, miso_nxt;
  logic misoOe_r, misoOe_nxt;
  logic active_r, active_nxt;
  logic rxSet;
  logic rxClr;
  logic shiftOn;
  logic linked;

  assign shiftOn = (state_r == sepc_pkg::IF_ACTIVE);
  assign linked = shiftOn | (state_r == sepc_pkg::IF_PAUSED);

  always_comb
  begin
    bitCnt_nxt = bitCnt_r;
    rxShift_nxt = rxShift_r;
    rxData_nxt = rxData_r;
    txShift_nxt = txShift_r;
    miso_nxt = miso_r;
    rxSet = 1'b0;
    if (!linked || state_nxt == sepc_pkg::IF_DESEL)
    begin
      bitCnt_nxt = `SEPC_BIT_FIRST;
      rxShift_nxt = `SEPC_BYTE_RST;
    end
    else if (shiftOn)
    begin
      // Pause leaves the counter and shifters untouched, so shifting resumes in place.
      if (sclkRise)
      begin
        rxShift_nxt = {rxShift_r[6:0], syncB_r.mosi};
        bitCnt_nxt = 3'(bitCnt_r + `SEPC_BIT_ONE);
        if (bitCnt_r == `SEPC_BIT_LAST)
        begin
          rxData_nxt = {rxShift_r[6:0], syncB_r.mosi};
          rxSet = 1'b1;
        end
      end
      if (sclkFall)
      begin
        if (bitCnt_r == `SEPC_BIT_FIRST)
        begin
          miso_nxt = txData_r[7];
          txShift_nxt = {txData_r[6:0], 1'b0};
        end
        else
        begin
          miso_nxt = txShift_r[7];
          txShift_nxt = {txShift_r[6:0], 1'b0};
        end
      end
    end
    // A byte landing in the cycle that software acknowledges the previous one wins.
    rxFull_nxt = rxSet | (rxFull_r & ~rxClr);
    misoOe_nxt = (state_nxt == sepc_pkg::IF_ACTIVE);
    active_nxt = (state_nxt == sepc_pkg::IF_ACTIVE) |
                 (state_nxt == sepc_pkg::IF_PAUSED);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bitCnt_r <= `SEPC_BIT_FIRST;
      rxShift_r <= `SEPC_BYTE_RST;
      rxData_r <= `SEPC_BYTE_RST;
      txShift_r <= `SEPC_TX_RST;
      rxFull_r <= 1'b0;
      miso_r <= 1'b1;
      misoOe_r <= 1'b0;
      active_r <= 1'b0;
    end
    else
    begin
      bitCnt_r <= bitCnt_nxt;
      rxShift_r <= rxShift_nxt;
      rxData_r <= rxData_nxt;
      txShift_r <= txShift_nxt;
      rxFull_r <= rxFull_nxt;
      miso_r <= miso_nxt;
      misoOe_r <= misoOe_nxt;
      active_r <= active_nxt;
    end
  end

  // Register port and status bits.
  logic waitReq_r, waitReq_nxt;
  logic [`SEPC_DATA_W-1:0] rdData_r, rdData_nxt;
  logic busy_r, busy_nxt;
  logic wel_r, wel_nxt;
  logic [2:0] nv_r, nv_nxt;
  logic nvLoaded_r, nvLoaded_nxt;
  logic refused_r, refused_nxt;
  logic [`SEPC_DATA_W-1:0] statWord;
  logic wrTake;
  logic rdLaunch;
  logic refSet;
  logic refClr;

  assign wrTake = avs_write & ~waitReq_r;
  assign rdLaunch = avs_read & waitReq_r;

  always_comb
  begin
    statWord = `SEPC_WORD_ZERO;
    statWord[`SEPC_ST_BUSY] = busy_r;
    statWord[`SEPC_ST_WEL] = wel_r;
    statWord[`SEPC_ST_NV_MSB:`SEPC_ST_NV_LSB] = nv_r;
    statWord[`SEPC_ST_SEL] = linked;
    statWord[`SEPC_ST_PAUSE] = (state_r == sepc_pkg::IF_PAUSED);
    statWord[`SEPC_ST_RXFULL] = rxFull_r;
    statWord[`SEPC_ST_WPLOW] = ~syncB_r.wpN;
    statWord[`SEPC_ST_REFUSED] = refused_r;
    statWord[`SEPC_ST_ACTIVE] = active_r;
  end

  always_comb
  begin
    waitReq_nxt = ~((avs_read | avs_write) & waitReq_r);
    rdData_nxt = rdData_r;
    busy_nxt = busy_r;
    wel_nxt = wel_r;
    nv_nxt = nv_r;
    nvLoaded_nxt = 1'b1;
    txData_nxt = txData_r;
    refSet = 1'b0;
    refClr = 1'b0;
    rxClr = 1'b0;
    if (!nvLoaded_r)
      nv_nxt = nvBits;
    if (rdLaunch)
    begin
      case (regSel(avs_address))
        sepc_pkg::REG_STAT: rdData_nxt = statWord;
        sepc_pkg::REG_RX: rdData_nxt = {24'h00_0000, rxData_r};
        sepc_pkg::REG_TX: rdData_nxt = {24'h00_0000, txData_r};
        default: rdData_nxt = `SEPC_WORD_ZERO;
      endcase
    end
    if (wrTake)
    begin
      case (regSel(avs_address))
        sepc_pkg::REG_CTRL:
        begin
          if (avs_writedata[`SEPC_CTL_SETWEL])
            wel_nxt = 1'b1;
          if (avs_writedata[`SEPC_CTL_CLRWEL])
            wel_nxt = 1'b0;
          if (avs_writedata[`SEPC_CTL_START])
          begin
            if (!syncB_r.wpN || !wel_r || busy_r)
              refSet = 1'b1;
            else
            begin
              busy_nxt = 1'b1;
              wel_nxt = 1'b0;
            end
          end
          if (avs_writedata[`SEPC_CTL_DONE])
            busy_nxt = 1'b0;
          rxClr = avs_writedata[`SEPC_CTL_RXACK];
          refClr = avs_writedata[`SEPC_CTL_CLRREF];
        end
        sepc_pkg::REG_STAT:
        begin
          if (wel_r && nvLoaded_r)
            nv_nxt = avs_writedata[`SEPC_ST_NV_MSB:`SEPC_ST_NV_LSB];
        end
        sepc_pkg::REG_TX:
          txData_nxt = avs_writedata[7:0];
        default:
          txData_nxt = txData_r;
      endcase
    end
    refused_nxt = refSet | (refused_r & ~refClr);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      waitReq_r <= 1'b1;
      rdData_r <= `SEPC_WORD_ZERO;
      busy_r <= 1'b0;
      wel_r <= 1'b0;
      nv_r <= `SEPC_NV_RST;
      nvLoaded_r <= 1'b0;
      refused_r <= 1'b0;
      txData_r <= `SEPC_TX_RST;
    end
    else
    begin
      waitReq_r <= waitReq_nxt;
      rdData_r <= rdData_nxt;
      busy_r <= busy_nxt;
      wel_r <= wel_nxt;
      nv_r <= nv_nxt;
      nvLoaded_r <= nvLoaded_nxt;
      refused_r <= refused_nxt;
      txData_r <= txData_nxt;
    end
  end

  assign avs_waitrequest = waitReq_r;
  assign avs_readdata = rdData_r;
  assign miso = miso_r;
  assign misoOe = misoOe_r;
  assign activeMode = active_r;

endmodule

/* File: test/sepc_pin_ctrl_chk.sv */
// Port-level assertions for the pin-control front end.
// Assumes clk and the asynchronous active-low arst_n of the design.
`timescale 1ns/1ps
module sepc_pin_ctrl_chk (
  input wire logic clk,
  input wire logic arst_n,
  input sepc_pkg::sepc_pins_t pinsIn,
  input wire logic miso,
  input wire logic misoOe,
  input wire logic activeMode,
  input wire logic avs_waitrequest
);
  logic seenHi_r;
  logic seenHi_nxt;
  always_comb seenHi_nxt = seenHi_r | pinsIn.selN;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      seenHi_r <= 1'b0;
    else
      seenHi_r <= seenHi_nxt;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_desel_float: assert property (pinsIn.selN [*6] |-> !misoOe)
    else $error("output driven while deselected");
  a_desel_standby: assert property (pinsIn.selN [*6] |-> !activeMode)
    else $error("active while deselected");
  a_pause_float: assert property ((!pinsIn.holdN && !pinsIn.sclk) [*7] |-> !misoOe)
    else $error("output driven while paused");
  a_live_drive: assert property ((!pinsIn.selN && pinsIn.holdN && !pinsIn.sclk) [*6] ##0
    activeMode |=> misoOe)
    else $error("output not driven while selected");
  a_unarmed_idle: assert property (!seenHi_r |-> !activeMode)
    else $error("selected without a select edge");
  a_reset_idle: assert property ($rose(arst_n) |-> !activeMode && !misoOe
    && avs_waitrequest)
    else $error("not idle after reset");
  a_rise_cause: assert property ($rose(activeMode) |-> !($past(pinsIn.selN, 3)
    && $past(pinsIn.selN, 4) && $past(pinsIn.selN, 5)))
    else $error("active without select");
  a_drop_cause: assert property ($fell(misoOe) |-> $past(pinsIn.selN | ~pinsIn.holdN, 3)
    || $past(pinsIn.selN | ~pinsIn.holdN, 4))
    else $error("output released without cause");
  a_miso_hold: assert property (pinsIn.sclk [*6] |=> $stable(miso))
    else $error("output moved without clock fall");
endmodule
bind sepc_pin_ctrl sepc_pin_ctrl_chk u_chk (.clk(clk), .arst_n(arst_n), .pinsIn(pinsIn),
  .miso(miso), .misoOe(misoOe), .activeMode(activeMode), .avs_waitrequest(avs_waitrequest));

/* File: test/sepc_spi_master.sv */
// Behavioural bus master that drives the serial pins, mode 0, 160 ns bit period.
// Assumes a 5 ns clk; the shift clock stands low between frames.
`timescale 1ns/1ps
module sepc_spi_master (
  input wire logic clk,
  input wire logic wpN,
  input wire logic miso,
  input wire logic misoOe,
  output sepc_pkg::sepc_pins_t pins
);
  logic qLast_r = 1'b0;
  // A floating line shows the inverse of its last driven level.
  wire logic qWire = misoOe ? miso : ~qLast_r;
  initial pins = '{sclk: 1'b0, selN: 1'b1, mosi: 1'b0, holdN: 1'b1, wpN: 1'b1};
  always @(posedge clk)
  begin
    pins.wpN <= wpN;
    if (misoOe)
      qLast_r <= miso;
  end
  task automatic sel(input logic v);
    repeat (4) @(posedge clk);
    pins.selN <= v;
    repeat (8) @(posedge clk);
  endtask
  task automatic hold(input logic v);
    // The shift clock must already stand low when the pause line moves.
    repeat (4) @(posedge clk);
    pins.holdN <= v;
    repeat (8) @(posedge clk);
  endtask
  task automatic bits(input logic [7:0] v, input int n, output logic [7:0] r);
    r = 8'h00;
    for (int i = 0; i < n; i++)
    begin
      pins.mosi <= v[7-i];
      repeat (16) @(posedge clk);
      pins.sclk <= 1'b1;
      r = {r[6:0], qWire};
      repeat (16) @(posedge clk);
      pins.sclk <= 1'b0;
    end
  endtask
endmodule

/* File: test/sepc_pin_ctrl_tb_top.sv */
// Self-checking bench: register bus tasks plus the serial master model.
// Assumes the bound checker and sepc_spi_master.
`timescale 1ns/1ps
`include "sepc_params.svh"
module sepc_pin_ctrl_tb_top;
  logic clk = 1'b0;
  logic arst_n;
  logic wpN;
  logic [2:0] nvBits;
  logic [`SEPC_ADDR_W-1:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, miso, misoOe, activeMode;
  sepc_pkg::sepc_pins_t pins;
  int n_mismatch = 0;
  int total_checks = 0;
  logic [31:0] q;
  logic [7:0] r;
  always #2.5 clk = ~clk;
  sepc_pin_ctrl DUT (.clk(clk), .arst_n(arst_n), .pinsIn(pins), .nvBits(nvBits),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .miso(miso), .misoOe(misoOe), .activeMode(activeMode));
  sepc_spi_master u_m (.clk(clk), .wpN(wpN), .miso(miso), .misoOe(misoOe), .pins(pins));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= ~w;
    avs_write <= w;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 64);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
    if (n >= 64)
      n_mismatch++;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(q & m, e);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    arst_n <= 1'b0;
    wpN <= 1'b1;
    nvBits <= 3'h5;
    avs_address <= 4'h0;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_writedata <= 32'h0000_0000;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rdchk(`SEPC_OFF_STAT, 32'h0000_07FF, 32'h0000_0014);
    rdchk(`SEPC_OFF_TX, 32'h0000_00FF, 32'h0000_00FF);
    rdchk(4'h2, 32'hFFFF_FFFF, 32'h0000_0000);
    // Select falls while reset is held, so no falling edge is seen after release.
    arst_n <= 1'b0;
    nvBits <= 3'h6;
    @(posedge clk);
    u_m.sel(1'b0);
    arst_n <= 1'b1;
    u_m.bits(8'hFF, 8, r);
    chk(activeMode, 1'b0);
    rdchk(`SEPC_OFF_STAT, 32'h0000_04A0, 32'h0000_0000);
    rdchk(`SEPC_OFF_STAT, 32'h0000_001C, 32'h0000_0018);
    u_m.sel(1'b1);
    bus(1'b1, `SEPC_OFF_TX, 32'h0000_00A5);
    u_m.sel(1'b0);
    chk(activeMode, 1'b1);
    u_m.bits(8'hE0, 3, r);
    u_m.sel(1'b1);
    u_m.sel(1'b0);
    u_m.bits(8'h3C, 8, r);
    rdchk(`SEPC_OFF_RX, 32'h0000_00FF, 32'h0000_003C);
    rdchk(`SEPC_OFF_STAT, 32'h0000_04A0, 32'h0000_04A0);
    u_m.bits(8'h00, 8, r);
    chk(r, 8'hA5);
    bus(1'b1, `SEPC_OFF_CTRL, 32'h0000_0010);
    u_m.sel(1'b1);
    chk(activeMode, 1'b0);
    u_m.sel(1'b0);
    u_m.bits(8'hC3, 4, r);
    u_m.hold(1'b0);
    chk(misoOe, 1'b0);
    rdchk(`SEPC_OFF_STAT, 32'h0000_0060, 32'h0000_0060);
    u_m.bits(8'h00, 4, r);
    u_m.hold(1'b1);
    chk(misoOe, 1'b1);
    u_m.bits(8'h30, 4, r);
    rdchk(`SEPC_OFF_RX, 32'h0000_00FF, 32'h0000_00C3);
    u_m.bits(8'hF0, 4, r);
    u_m.hold(1'b0);
    u_m.sel(1'b1);
    u_m.hold(1'b1);
    u_m.sel(1'b0);
    u_m.bits(8'h5A, 8, r);
    rdchk(`SEPC_OFF_RX, 32'h0000_00FF, 32'h0000_005A);
    u_m.sel(1'b1);
    u_m.hold(1'b0);
    rdchk(`SEPC_OFF_STAT, 32'h0000_0060, 32'h0000_0000);
    u_m.hold(1'b1);
    bus(1'b1, `SEPC_OFF_CTRL, 32'h0000_0001);
    wpN <= 1'b0;
    repeat (8) @(posedge clk);
    bus(1'b1, `SEPC_OFF_CTRL, 32'h0000_0004);
    rdchk(`SEPC_OFF_STAT, 32'h0000_0303, 32'h0000_0302);
    bus(1'b1, `SEPC_OFF_CTRL, 32'h0000_0020);
    wpN <= 1'b1;
    repeat (8) @(posedge clk);
    bus(1'b1, `SEPC_OFF_CTRL, 32'h0000_0004);
    rdchk(`SEPC_OFF_STAT, 32'h0000_0303, 32'h0000_0001);
    bus(1'b1, `SEPC_OFF_CTRL, 32'h0000_0008);
    bus(1'b1, `SEPC_OFF_CTRL, 32'h0000_0001);
    bus(1'b1, `SEPC_OFF_STAT, 32'h0000_0004);
    rdchk(`SEPC_OFF_STAT, 32'h0000_001F, 32'h0000_0006);
    bus(1'b1, `SEPC_OFF_CTRL, 32'h0000_0002);
    bus(1'b1, `SEPC_OFF_STAT, 32'h0000_0010);
    rdchk(`SEPC_OFF_STAT, 32'h0000_001F, 32'h0000_0004);
    stop_test();
  end
  initial
  begin
    #100000;
    n_mismatch++;
    stop_test();
  end
endmodule
